// [rtl/btpc_regs.vh]
// Purpose: Constants for the branch target and program counter unit.
// Assumes: 16-bit instruction address space.
// Notes:   Included by btpc_unit.v only.
`ifndef BTPC_REGS_VH
`define BTPC_REGS_VH
`define BTPC_PC_RESET      16'h0000
`define BTPC_TABLE_BASE    16'h0040
`define BTPC_TABLE_LAST    16'h007f
`define BTPC_SEL_LSB       1
`define BTPC_SEL_MSB       5
`define BTPC_SIGN_BIT      7
`define BTPC_MODE_SEQ      3'h0
`define BTPC_MODE_REL      3'h1
`define BTPC_MODE_ABS      3'h2
`define BTPC_MODE_TABLE    3'h3
`define BTPC_MODE_REG      3'h4
`define BTPC_ST_IDLE       2'h0
`define BTPC_ST_LOW        2'h1
`define BTPC_ST_HIGH       2'h2
`define BTPC_ST_STEP       2'h3
`endif

// [rtl/btpc_unit.v]
// Purpose: Program counter and branch target formation for an 8-bit core.
// Assumes: Decoder presents one request per cycle on a single-cycle strobe;
//          table bytes return one cycle after the read address is shown.
// Notes:   All outputs are registered.
//          Requests offered while BUSY_OUT is high are dropped silently.
//          A table walk takes four edges from request to new PC_OUT,
//          because each table byte costs one address cycle and one data cycle.
`timescale 1ns/1ps
`include "btpc_regs.vh"
module btpc_unit (
    // Clock and reset
    input  wire        CLK_SYS_IN,
    input  wire        RST_IN,
    // Decoder request
    input  wire        REQ_VALID_IN,
    input  wire [2:0]  MODE_IN,
    input  wire [1:0]  INSTR_LENGTH_IN,
    input  wire [7:0]  INSTR_CODE_IN,
    input  wire [7:0]  RELATIVE_DISPLACEMENT_IN,
    input  wire [15:0] ABSOLUTE_TARGET_FIELD_IN,
    input  wire [15:0] ACCUMULATOR_PAIR_IN,
    // Table memory read port
    input  wire [7:0]  TABLE_DATA_IN,
    output reg         TABLE_READ_OUT,
    output reg  [15:0] TABLE_ADDR_OUT,
    // Next fetch address
    output reg  [15:0] PC_OUT,
    output reg         BUSY_OUT
);
    // Walk state and staged low table byte.
    reg  [1:0]  state;
    reg  [7:0]  low_byte;

    // Next values of every register.
    reg  [1:0]  next_state;
    reg  [7:0]  next_low_byte;
    reg  [15:0] next_pc;
    reg  [15:0] next_table_addr;
    reg         next_table_read;
    reg         next_busy;

    // Target formation.
    wire        take_req;
    wire [7:0]  sign_fill;
    wire [15:0] next_seq;
    wire [15:0] disp_ext;
    wire [15:0] rel_target;
    wire [4:0]  table_entry_selector;
    wire [15:0] table_entry_addr;
    wire [15:0] table_target;
    genvar      bit_idx;

    // Requests are taken only while idle; a table walk owns the read
    // port for three cycles, so anything offered then is dropped.
    assign take_req = REQ_VALID_IN && (state == `BTPC_ST_IDLE);

    assign next_seq =
        PC_OUT + {14'h0000, INSTR_LENGTH_IN};

    // Every upper bit of the displacement copies its sign bit.
    generate
        for (bit_idx = 0; bit_idx < 8; bit_idx = bit_idx + 1) begin : g_sign
            assign sign_fill[bit_idx] =
                RELATIVE_DISPLACEMENT_IN[`BTPC_SIGN_BIT];
        end
    endgenerate

    assign disp_ext = {sign_fill, RELATIVE_DISPLACEMENT_IN};
    assign rel_target =
        next_seq + disp_ext;

    assign table_entry_selector =
        INSTR_CODE_IN[`BTPC_SEL_MSB:`BTPC_SEL_LSB];
    assign table_entry_addr = `BTPC_TABLE_BASE |
        {10'h000, table_entry_selector, 1'b0};
    assign table_target =
        {TABLE_DATA_IN, low_byte};

    // Next-value logic. Every register holds unless a case item moves it,
    // so no path leaves a next value unassigned.
    always @* begin
        next_state      = state;
        next_low_byte   = low_byte;
        next_pc         = PC_OUT;
        next_table_addr = TABLE_ADDR_OUT;
        next_table_read = TABLE_READ_OUT;
        next_busy       = BUSY_OUT;

        case (state)
            `BTPC_ST_IDLE: begin
                next_table_read = 1'b0;
                next_busy       = 1'b0;
                if (take_req) begin
                    case (MODE_IN)
                        `BTPC_MODE_SEQ: begin
                            next_pc = next_seq;
                        end

                        `BTPC_MODE_REL: begin
                            next_pc = rel_target;
                        end

                        `BTPC_MODE_ABS: begin
                            next_pc = ABSOLUTE_TARGET_FIELD_IN;
                        end

                        `BTPC_MODE_REG: begin
                            next_pc = ACCUMULATOR_PAIR_IN;
                        end

                        `BTPC_MODE_TABLE: begin
                            next_table_addr = table_entry_addr;
                            next_table_read = 1'b1;
                            next_busy       = 1'b1;
                            next_state      = `BTPC_ST_STEP;
                        end

                        default: begin
                            next_pc = PC_OUT;
                        end
                    endcase
                end
            end

            `BTPC_ST_STEP: begin
                next_table_addr = TABLE_ADDR_OUT + 16'h0001;
                next_state      = `BTPC_ST_LOW;
            end

            `BTPC_ST_LOW: begin
                next_low_byte   = TABLE_DATA_IN;
                next_table_read = 1'b0;
                next_state      = `BTPC_ST_HIGH;
            end

            `BTPC_ST_HIGH: begin
                next_pc    = table_target;
                next_busy  = 1'b0;
                next_state = `BTPC_ST_IDLE;
            end

            default: begin
                next_table_read = 1'b0;
                next_busy       = 1'b0;
                next_state      = `BTPC_ST_IDLE;
            end
        endcase
    end

    // Registers. Each reset branch loads constants only.
    // Walk state.
    always @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state <= `BTPC_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Low table byte, kept until the high byte arrives.
    always @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            low_byte <= 8'h00;
        end else begin
            low_byte <= next_low_byte;
        end
    end

    // Program counter; it stands until a taken sequential, relative, absolute
    // or register request, or the end of a table walk.
    always @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            PC_OUT <= `BTPC_PC_RESET;
        end else begin
            PC_OUT <= next_pc;
        end
    end

    // Table byte address.
    always @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            TABLE_ADDR_OUT <= 16'h0000;
        end else begin
            TABLE_ADDR_OUT <= next_table_addr;
        end
    end

    // Table read strobe.
    always @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            TABLE_READ_OUT <= 1'b0;
        end else begin
            TABLE_READ_OUT <= next_table_read;
        end
    end

    // Busy flag; any request offered while this is high is dropped.
    always @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            BUSY_OUT <= 1'b0;
        end else begin
            BUSY_OUT <= next_busy;
        end
    end

endmodule // btpc_unit

// [verif/btpc_table_mem.sv]
// Purpose: Table memory model.
// Assumes: Byte is address xor a5.
// Notes: One cycle of read latency.
`timescale 1ns/1ps
module btpc_table_mem (
    input  wire        CLK_SYS_IN,
    input  wire [15:0] TABLE_ADDR_OUT,
    output reg  [7:0]  TABLE_DATA_IN
);
    // The byte for the address shown at one edge appears after that edge.
    initial TABLE_DATA_IN = 8'h00;
    always @(posedge CLK_SYS_IN) begin
        TABLE_DATA_IN <= TABLE_ADDR_OUT[7:0] ^ 8'ha5;
    end
endmodule // btpc_table_mem

// [verif/btpc_unit_sva.sv]
// Purpose: Port checks.
// Assumes: One clock.
// Notes: Bound below.
`timescale 1ns/1ps
module btpc_unit_sva (
    input wire        CLK_SYS_IN,
    input wire        RST_IN,
    input wire        REQ_VALID_IN,
    input wire        BUSY_OUT,
    input wire        TABLE_READ_OUT,
    input wire [2:0]  MODE_IN,
    input wire [1:0]  INSTR_LENGTH_IN,
    input wire [7:0]  INSTR_CODE_IN,
    input wire [7:0]  RELATIVE_DISPLACEMENT_IN,
    input wire [15:0] ABSOLUTE_TARGET_FIELD_IN,
    input wire [15:0] ACCUMULATOR_PAIR_IN,
    input wire [15:0] TABLE_ADDR_OUT,
    input wire [15:0] PC_OUT
);
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);
    wire go = REQ_VALID_IN && !BUSY_OUT;
    wire [15:0] disp_ext = {{8{RELATIVE_DISPLACEMENT_IN[7]}},
                            RELATIVE_DISPLACEMENT_IN};
    AST_SEQ: assert property (go && MODE_IN == 3'h0 |=>
        PC_OUT == $past(PC_OUT) + $past(INSTR_LENGTH_IN)) else $error("seq");
    AST_REL: assert property (go && MODE_IN == 3'h1 |=>
        PC_OUT == $past(PC_OUT) + $past(INSTR_LENGTH_IN) + $past(disp_ext))
        else $error("rel");
    AST_ABS: assert property (go && MODE_IN == 3'h2 |=>
        PC_OUT == $past(ABSOLUTE_TARGET_FIELD_IN)) else $error("abs");
    AST_REG: assert property (go && MODE_IN == 3'h4 |=>
        PC_OUT == $past(ACCUMULATOR_PAIR_IN)) else $error("reg");
    AST_RANGE: assert property (TABLE_READ_OUT |->
        TABLE_ADDR_OUT >= 16'h0040 && TABLE_ADDR_OUT <= 16'h007f)
        else $error("range");
    AST_WALK: assert property (go && MODE_IN == 3'h3 |=>
        BUSY_OUT[*3] ##1 !BUSY_OUT) else $error("walk");
    AST_STEP: assert property (go && MODE_IN == 3'h3 |=>
        ##1 TABLE_ADDR_OUT == $past(TABLE_ADDR_OUT) + 16'h0001)
        else $error("step");
    AST_TBL: assert property (go && MODE_IN == 3'h3 |=>
        TABLE_READ_OUT && BUSY_OUT && TABLE_ADDR_OUT ==
        {10'h001, $past(INSTR_CODE_IN[5:1]), 1'b0}) else $error("tbl");
endmodule // btpc_unit_sva
bind btpc_unit btpc_unit_sva u_sva (.*);

// [verif/btpc_unit_bench.sv]
// Purpose: Directed bench.
// Assumes: Inputs change on falling edges.
// Notes: Fixed wait covers the table walk.
`timescale 1ns/1ps
module btpc_unit_bench;
    reg CLK_SYS_IN = 0, RST_IN = 1, REQ_VALID_IN = 0;
    reg [2:0] MODE_IN = 0;
    reg [1:0] INSTR_LENGTH_IN = 0;
    reg [7:0] INSTR_CODE_IN = 0, RELATIVE_DISPLACEMENT_IN = 0;
    reg [15:0] ABSOLUTE_TARGET_FIELD_IN = 0, ACCUMULATOR_PAIR_IN = 0;
    wire [7:0] TABLE_DATA_IN;
    wire TABLE_READ_OUT, BUSY_OUT;
    wire [15:0] TABLE_ADDR_OUT, PC_OUT;
    integer n_fail = 0, samples_checked = 0, cyc = 0;
    btpc_unit u_dut (.*);
    btpc_table_mem u_mem (.*);
    always #5 CLK_SYS_IN = ~CLK_SYS_IN;
    task end_sim; begin
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    end endtask
    task req(input [2:0] m, input [1:0] l, input [7:0] c, d,
             input [15:0] v, e); begin
        @(negedge CLK_SYS_IN);
        {REQ_VALID_IN, MODE_IN, INSTR_LENGTH_IN} = {1'b1, m, l};
        {INSTR_CODE_IN, RELATIVE_DISPLACEMENT_IN} = {c, d};
        ABSOLUTE_TARGET_FIELD_IN = v;
        ACCUMULATOR_PAIR_IN = v ^ 16'h0f0f;
        @(negedge CLK_SYS_IN) REQ_VALID_IN = 0;
        repeat (4) @(negedge CLK_SYS_IN);
        samples_checked = samples_checked + 1;
        if (PC_OUT !== e) begin
            n_fail = n_fail + 1;
            $display("FAIL PC_OUT exp %h got %h", e, PC_OUT);
        end
    end endtask
    always @(posedge CLK_SYS_IN) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin n_fail = n_fail + 1; end_sim; end
    end
    task seq_step; req(0, 3, 0, 0, 0, 16'h0003); endtask
    task rel_back; req(1, 2, 0, 8'h80, 0, 16'hff85); endtask
    task abs_jump; req(2, 1, 0, 0, 16'hbeef, 16'hbeef); endtask
    task rel_fwd; req(1, 2, 0, 8'h7f, 0, 16'hbf70); endtask
    task reg_jump; req(4, 1, 0, 0, 16'h1234, 16'h1d3b); endtask
    task table_top; req(3, 1, 8'h3e, 0, 0, 16'hdadb); endtask
    task table_bottom; req(3, 1, 8'hc1, 0, 0, 16'he4e5); endtask
    task hold_mode; req(5, 1, 0, 0, 16'h9999, 16'he4e5); endtask
    task table_busy; begin
        @(negedge CLK_SYS_IN);
        {REQ_VALID_IN, MODE_IN, INSTR_CODE_IN} = {1'b1, 3'h3, 8'h02};
        @(negedge CLK_SYS_IN) MODE_IN = 3'h2;
        ABSOLUTE_TARGET_FIELD_IN = 16'h5555;
        samples_checked = samples_checked + 1;
        if (BUSY_OUT !== 1'b1) begin
            n_fail = n_fail + 1;
            $display("FAIL BUSY_OUT exp 1 got %b", BUSY_OUT);
        end
        repeat (3) @(negedge CLK_SYS_IN);
        REQ_VALID_IN = 0;
        samples_checked = samples_checked + 2;
        if (BUSY_OUT !== 1'b0) begin
            n_fail = n_fail + 1;
            $display("FAIL BUSY_OUT exp 0 got %b", BUSY_OUT);
        end
        if (PC_OUT !== 16'he6e7) begin
            n_fail = n_fail + 1;
            $display("FAIL PC_OUT exp e6e7 got %h", PC_OUT);
        end
    end endtask
    initial begin
        repeat (20) @(negedge CLK_SYS_IN);
        RST_IN = 0;
        seq_step;
        rel_back;
        abs_jump;
        rel_fwd;
        reg_jump;
        table_top;
        table_bottom;
        hold_mode;
        table_busy;
        end_sim;
    end
endmodule // btpc_unit_bench
